// file: core/tmc_test_mode_control.v
/*
 * Test-mode control of an octal serial link multiplexer: the two test
 * registers reached on the parallel port when the test space address
 * line is high, tri-state control of outputs and data bus, and the
 * test-mode and link-under-test outputs to the rest of the chip.
 * Assumes all port pins are synchronous to ref_clk; a write is taken on
 * the cycle where chip select and write strobe first go low together.
 */
// Operation
// - All three strobes low together floats every digital output and the data bus.
// - Address line nine high steers accesses to the test register space.
// - Unused bits ignore writes; reads may return either value; software masks them.
// - Writable test bits stay uninitialised by reset unless stated otherwise.
// - Device reset clears master test register except both factory test bits.
// - Software reset bit leaves the master test register untouched.
// - Output float bit tri-states all outputs but data bus and scan out.
// - Data float bit floats the data bus; drive-by-select overrides it while either test mode is on.
// - Board test bit holds all internal blocks in test mode.
// - Drive-by-select with any test mode: chip select high drives the bus.
// - Factory test bit makes the port a vector port; ORed with board test.
// - Factory test bit clears on chip select high or a written zero.
// - Factory analog bit clears on chip select high with reset pin low, or zero written.
// - Link-under-test selector clears whenever chip select is high.
// - Writing zero to any test control bit clears that bit.
// - Selector picks the link under test while either test mode is on.
// - Reset pin leaves the selector unchanged; tester writes it before testing.
// - Boundary scan samples inputs and forces outputs except the serial pairs.
`timescale 1ns/1ps
`default_nettype none
`include "tmc_consts.vh"

module tmc_test_mode_control (
    // Clock and device reset
    input wire ref_clk,
    input wire sys_rst,
    // Microprocessor port
    input wire chip_select_n,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire reset_pin_n,
    input wire [9:0] addr,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg data_oe_n,
    // Pin tri-state and test controls to the chip
    output reg outputs_oe_n,
    output reg blocks_test_mode,
    output reg factory_port_mode,
    output reg factory_analog_mode,
    output reg [2:0] link_under_test,
    output reg link_test_valid
);

    // Master test register fields; the factory bits have no reset
    reg float_outputs;
    reg float_data_bus;
    reg board_test_enable;
    reg bus_drive_by_select;
    reg factory_test_enable;
    reg factory_analog_test;
    reg reserved_bit;
    reg [`TMC_LINK_W-1:0] link_sel;
    reg wr_d;

    wire test_space;
    wire wr_now;
    wire wr_edge;
    wire rd_now;
    wire all_low;
    wire any_test;
    wire hit_master;
    wire hit_link;
    reg next_data_oe_n;
    reg [7:0] next_rdata;

    // Test space is picked by address line nine alone
    assign test_space = addr[`TMC_TEST_SEL_BIT];
    assign hit_master = test_space && (addr == `TMC_OFS_MASTER_TEST);
    assign hit_link = test_space && (addr == `TMC_OFS_LINK_SELECT);
    assign all_low = !chip_select_n && !read_strobe_n && !write_strobe_n;
    assign wr_now = !chip_select_n && !write_strobe_n && read_strobe_n;
    assign wr_edge = wr_now && !wr_d;
    assign rd_now = !chip_select_n && !read_strobe_n && write_strobe_n;
    assign any_test = board_test_enable || factory_test_enable;

    // Strobe history, so a long write is taken only once
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            wr_d <= 1'b0;
        end else begin
            wr_d <= wr_now;
        end
    end

    // Resettable master test bits; the software reset bit has no path here
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            float_outputs <= 1'b0;
            float_data_bus <= 1'b0;
            board_test_enable <= 1'b0;
            bus_drive_by_select <= 1'b0;
            reserved_bit <= 1'b0;
        end else if (wr_edge && hit_master) begin
            float_outputs <= data_in[`TMC_BIT_FLOAT_OUTPUTS];
            float_data_bus <= data_in[`TMC_BIT_FLOAT_DATA];
            board_test_enable <= data_in[`TMC_BIT_BOARD_TEST];
            bus_drive_by_select <= data_in[`TMC_BIT_DRIVE_BY_SEL];
            reserved_bit <= data_in[`TMC_BIT_RESERVED];
        end
    end

    // Factory bits ignore device reset and clear from pin conditions instead
    always @(posedge ref_clk) begin
        if (chip_select_n) begin
            factory_test_enable <= 1'b0;
        end else if (wr_edge && hit_master) begin
            factory_test_enable <= data_in[`TMC_BIT_FACTORY_TEST];
        end
        if (chip_select_n && !reset_pin_n) begin
            factory_analog_test <= 1'b0;
        end else if (wr_edge && hit_master) begin
            factory_analog_test <= data_in[`TMC_BIT_FACTORY_ANALOG];
        end
    end

    // Selector: no reset at all, cleared by chip select high, written as one three-bit field
    // The reset pin has no path here, so testers must write it first
    always @(posedge ref_clk) begin
        if (chip_select_n) begin
            link_sel <= {`TMC_LINK_W{1'b0}};
        end else if (wr_edge && hit_link) begin
            link_sel <= data_in[`TMC_LINK_W-1:0];
        end
    end

    // Read data; write-only bits read as zero here, unused bits too
    always @* begin
        next_rdata = 8'h00;
        if (hit_master) begin
            next_rdata[`TMC_BIT_FLOAT_OUTPUTS] = float_outputs;
            next_rdata[`TMC_BIT_BOARD_TEST] = board_test_enable;
            next_rdata[`TMC_BIT_RESERVED] = reserved_bit;
        end else if (hit_link) begin
            next_rdata[`TMC_LINK_W-1:0] = link_sel;
        end
    end

    // Data bus enable, active low; strobe float beats everything
    always @* begin
        next_data_oe_n = 1'b1;
        if (all_low) begin
            next_data_oe_n = 1'b1;
        end else if (bus_drive_by_select && any_test) begin
            next_data_oe_n = !chip_select_n;
        end else if (float_data_bus) begin
            next_data_oe_n = 1'b1;
        end else begin
            next_data_oe_n = !(rd_now && test_space);
        end
    end

    // Registered outputs; the flop costs one cycle of read latency
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            data_out <= `TMC_RST_DOUT;
            data_oe_n <= 1'b1;
            outputs_oe_n <= 1'b0;
            blocks_test_mode <= 1'b0;
            factory_port_mode <= 1'b0;
            factory_analog_mode <= 1'b0;
            link_under_test <= 3'h0;
            link_test_valid <= 1'b0;
        end else begin
            data_out <= next_rdata;
            data_oe_n <= next_data_oe_n;
            // Serial pairs have no enable here, so scan and float leave them alone
            outputs_oe_n <= all_low || float_outputs;
            blocks_test_mode <= any_test;
            factory_port_mode <= factory_test_enable;
            factory_analog_mode <= factory_analog_test;
            link_under_test <= link_sel;
            link_test_valid <= any_test;
        end
    end

endmodule // tmc_test_mode_control
`default_nettype wire

// file: shared/tmc_consts.vh
/*
 * Constants of the test-mode control block: register offsets, field
 * positions and reset values. Assumes inclusion by bare name.
 */
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH

`define TMC_ADDR_W 10
`define TMC_TEST_SEL_BIT 9
`define TMC_OFS_MASTER_TEST 10'h200
`define TMC_OFS_LINK_SELECT 10'h201
`define TMC_BIT_FLOAT_OUTPUTS 0
`define TMC_BIT_FLOAT_DATA 1
`define TMC_BIT_BOARD_TEST 2
`define TMC_BIT_DRIVE_BY_SEL 3
`define TMC_BIT_FACTORY_TEST 4
`define TMC_BIT_FACTORY_ANALOG 5
`define TMC_BIT_RESERVED 6
`define TMC_LINK_W 3
`define TMC_RST_MASTER 8'h00
`define TMC_RST_DOUT 8'h00

`endif

// file: testbench/tmc_chk.sv
/* Port assertions for the test-mode control block.
   Assumes it is bound to tmc_test_mode_control; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module tmc_chk (
    // Clock, reset and processor port
    input wire logic ref_clk, sys_rst, chip_select_n, read_strobe_n, write_strobe_n, reset_pin_n,
    input wire logic [9:0] addr,
    // Outputs of the block
    input wire logic [7:0] data_out,
    input wire logic data_oe_n, outputs_oe_n, blocks_test_mode, factory_port_mode, factory_analog_mode,
    input wire logic [2:0] link_under_test,
    input wire logic link_test_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Two cycles of select high cover both register and output flop
    property p_all_low; !chip_select_n && !read_strobe_n && !write_strobe_n |=> data_oe_n && outputs_oe_n; endproperty
    a_all_low: assert property (p_all_low) else $error("strobes low did not float");
    property p_space; !chip_select_n && !addr[9] |=> data_oe_n; endproperty
    a_space: assert property (p_space) else $error("bus driven outside test space");
    property p_sel_clr; chip_select_n [*2] |=> link_under_test == 3'h0 && !factory_port_mode; endproperty
    a_sel_clr: assert property (p_sel_clr) else $error("select high did not clear");
    property p_ana_clr; (chip_select_n && !reset_pin_n) [*2] |=> !factory_analog_mode; endproperty
    a_ana_clr: assert property (p_ana_clr) else $error("analog bit not cleared");
    property p_valid; link_test_valid == blocks_test_mode; endproperty
    a_valid: assert property (p_valid) else $error("selector valid mismatch");
    property p_fac_or; factory_port_mode |-> blocks_test_mode; endproperty
    a_fac_or: assert property (p_fac_or) else $error("factory test not in test mode");
    property p_rst; $fell(sys_rst) |-> data_oe_n && !outputs_oe_n; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_wo; !chip_select_n && !read_strobe_n && write_strobe_n && addr == 10'h200 |=> (data_out & 8'hba) == 8'h00; endproperty
    a_wo: assert property (p_wo) else $error("write-only bits read nonzero");
endmodule // tmc_chk
`default_nettype wire

// file: testbench/tmc_host.sv
/* Processor model on the test register port.
   Assumes one clock; pins move 1 ns after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module tmc_host (
    // Clock and read-back
    input wire logic ref_clk, data_oe_n,
    input wire logic [7:0] data_out,
    // Port pins
    output logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1,
    output logic [9:0] addr = 10'h000,
    output logic [7:0] dq = 8'h00
);
    // Write strobe goes high again so the next write is a new strobe
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk) #1;
        {addr, dq, cs_n, wr_n} = {a, d, 2'b00};
        @(posedge ref_clk) #1;
        {wr_n, dq} = {1'b1, ~d}; // Released data changes value
    endtask
    // Answer taken one edge after the strobe; a float reads as inverted data
    task automatic rd(input logic [9:0] a, output logic [7:0] q);
        @(posedge ref_clk) #1;
        {addr, cs_n, rd_n} = {a, 2'b00};
        @(posedge ref_clk) #1;
        q = data_oe_n ? ~data_out : data_out;
        rd_n = 1'b1;
    endtask
endmodule // tmc_host
`default_nettype wire

// file: testbench/tb_top.sv
/* Table-driven bench for the test-mode control block.
   Assumes tmc_host drives the port and tmc_chk is bound. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0, sys_rst = 1'b1, reset_pin_n = 1'b0;
    logic cs_n, rd_n, wr_n, oe_n, ooe_n, btm, fpm, fam, ltv;
    logic [9:0] addr;
    logic [7:0] din, dout, q;
    logic [2:0] lut;
    int fails = 0, total_checks = 0;
    // Row: address, write data, read-back, board mode, outputs float
    logic [27:0] rows [0:5] = '{{10'h201, 8'h05, 8'h05, 2'b00}, {10'h201, 8'hfa, 8'h02, 2'b00},
        {10'h201, 8'h00, 8'h00, 2'b00}, {10'h200, 8'h04, 8'h04, 2'b10},
        {10'h200, 8'h05, 8'h05, 2'b11}, {10'h200, 8'h00, 8'h00, 2'b00}};
    initial forever #12.5 ref_clk = ~ref_clk;
    tmc_host host_u (.ref_clk(ref_clk), .data_oe_n(oe_n), .data_out(dout), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .dq(din));
    tmc_test_mode_control dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .chip_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .reset_pin_n(reset_pin_n), .addr(addr),
        .data_in(din), .data_out(dout), .data_oe_n(oe_n), .outputs_oe_n(ooe_n), .blocks_test_mode(btm),
        .factory_port_mode(fpm), .factory_analog_mode(fam), .link_under_test(lut), .link_test_valid(ltv));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        total_checks++;
        if (s !== e) begin fails++; $display("[ERR] %s expected %h seen %h", n, e, s); end
    endtask
    task automatic close_out;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Whole run is under a hundred cycles; this is ample
    initial begin #30us; fails++; close_out(); end
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 {sys_rst, reset_pin_n} = 2'b01;
        foreach (rows[i]) begin
            host_u.wr(rows[i][27:18], rows[i][17:10]);
            host_u.rd(rows[i][27:18], q);
            chk("readback", rows[i][9:2], q);
            chk("modes", {6'h0, rows[i][1:0]}, {6'h0, btm, ooe_n});
        end
        // All three strobes low
        {host_u.wr_n, host_u.rd_n} = 2'b00;
        @(posedge ref_clk) #1 chk("float all", 8'h03, {6'h0, oe_n, ooe_n});
        {host_u.wr_n, host_u.rd_n} = 2'b11;
        // Factory bits, then clears by chip select and reset pin
        host_u.wr(10'h201, 8'h07);
        host_u.wr(10'h200, 8'h30);
        @(posedge ref_clk) #1 chk("factory", 8'h0f, {4'h0, fpm, fam, btm, ltv});
        host_u.cs_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk("cs clear", 8'h04, {4'h0, fpm, fam, lut[1:0]});
        chk("sel top", 8'h00, {7'h0, lut[2]});
        reset_pin_n = 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 chk("analog", 8'h00, {7'h0, fam});
        {reset_pin_n, host_u.cs_n} = 2'b10;
        // Bus drive handed to chip select
        host_u.wr(10'h200, 8'h0c);
        repeat (2) @(posedge ref_clk);
        #1 chk("cs low float", 8'h01, {7'h0, oe_n});
        host_u.cs_n = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 chk("cs high drive", 8'h00, {7'h0, oe_n});
        host_u.wr(10'h200, 8'h07);
        host_u.rd(10'h200, q);
        chk("data float", 8'h03, {6'h0, oe_n, ooe_n});
        host_u.wr(10'h000, 8'hff);
        @(posedge ref_clk) #1 chk("normal space", 8'h01, {7'h0, btm});
        sys_rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        @(posedge ref_clk) #1 chk("after reset", 8'h02, {5'h0, btm, oe_n, ooe_n});
        close_out();
    end
endmodule // tb_top
bind tmc_test_mode_control tmc_chk chk_u (.*);
`default_nettype wire
